// File: hdl/fes_pkg.sv
// Shared constants for the flash error status link ends
package fes_pkg;

   // ==========================================================
   // Link command codes
   localparam logic [7:0] CMD_STAT_RD = 8'h70;
   localparam logic [7:0] CMD_STAT_CLR = 8'h50;
   localparam logic [7:0] CMD_ABORT_RST = 8'h2a;
   localparam logic [7:0] CMD_EXIT = 8'hf0;
   localparam logic [7:0] CMD_ECC_RD = 8'h75;
   localparam logic [7:0] CMD_TRAP_LO = 8'h76;
   localparam logic [7:0] CMD_TRAP_HI = 8'h77;
   localparam logic [7:0] CMD_ARR_RD = 8'h0b;
   localparam logic [7:0] CMD_PROG = 8'ha0;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_WBUF = 8'h25;

   // ==========================================================
   // Flash status word bit positions
   localparam int FSW_READY = 7;
   localparam int FSW_ERS = 6;
   localparam int FSW_ESF = 5;
   localparam int FSW_PGM = 4;
   localparam int FSW_ABT = 3;
   localparam logic [7:0] FSW_RST = 8'h00;

   // ==========================================================
   // ECC status word layout
   localparam logic [15:0] ECC_RST = 16'h0000;
   localparam logic [10:0] ECC_RSVD = 11'h000;
   localparam int UNITS = 16;
   localparam int UNIT_AW = 4;
   localparam int UNIT_LSB = 4;
   localparam logic [15:0] JUNK_WORD = 16'hffff;

   // ==========================================================
   // Trap high word masks per density
   localparam logic [1:0] DEN_128 = 2'h0;
   localparam logic [1:0] DEN_256 = 2'h1;
   localparam logic [1:0] DEN_512 = 2'h2;
   localparam logic [15:0] HI_MASK_128 = 16'h007f;
   localparam logic [15:0] HI_MASK_256 = 16'h00ff;
   localparam logic [15:0] HI_MASK_512 = 16'h01ff;

   // ==========================================================
   // Timing
   localparam int REF_PERIOD_NS = 4;
   localparam int LINK_PERIOD_NS = 16;
   localparam int LINK_DIV = LINK_PERIOD_NS / REF_PERIOD_NS;
   localparam logic [1:0] DIV_LAST = 2'(LINK_DIV - 1);
   localparam logic [1:0] DIV_HALF = 2'(LINK_DIV / 2);
   localparam logic [5:0] STALL_LIMIT = 6'h20;

endpackage

// File: hdl/fes_link_if.sv
// Byte link between host controller and flash error status end
`timescale 1ns/1ps
`default_nettype none
interface fes_link_if;
   logic link_clk;
   logic cs_n;
   logic [7:0] dq_h;
   logic h_oe_n;
   logic [7:0] dq_d;
   logic d_oe_n;
   logic [7:0] dq;
   logic read_data_strobe;
   logic int_n;

   // Shared data wire, pulled high when idle
   assign dq = !h_oe_n ? dq_h : (!d_oe_n ? dq_d : 8'hff);

   modport host (
      output link_clk,
      output cs_n,
      output dq_h,
      output h_oe_n,
      input dq,
      input read_data_strobe,
      input int_n
   );

   modport dev (
      input link_clk,
      input cs_n,
      input dq,
      output dq_d,
      output d_oe_n,
      output read_data_strobe,
      output int_n
   );
endinterface
`default_nettype wire

// File: hdl/fes_sync.sv
// Two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps
`default_nettype none
module fes_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } fes_sync_s;

   fes_sync_s state_ff;
   fes_sync_s nxt_state;

   // First stage feeds only the second
   always_comb
   begin
      nxt_state.meta = d;
      nxt_state.q = state_ff.meta;
   end

   always_ff @(posedge clk)
   begin
      state_ff <= nxt_state;
   end

   assign q = state_ff.q;
endmodule
`default_nettype wire

// File: hdl/fes_dev.sv
// Flash end: abort status, ECC status word, error address trap
`timescale 1ns/1ps
`default_nettype none
module fes_dev (
   fes_link_if.dev lnk,
   input wire logic reset_n,
   input wire logic arr_toggle,
   input wire logic [24:3] arr_addr,
   input wire logic arr_fix_data,
   input wire logic arr_fix_syn,
   input wire logic arr_double,
   input wire logic arr_unit_off,
   input wire logic arr_multi_prog,
   input wire logic op_toggle,
   input wire logic op_fail,
   input wire logic cfg_trap_both,
   input wire logic cfg_stall_off,
   input wire logic cfg_dbl_en,
   input wire logic cfg_int_en,
   input wire logic [1:0] cfg_density
);
   import fes_pkg::*;

   // ==========================================================
   // Types and state
   typedef enum logic [2:0] {
      DP_CMD = 3'b000,
      DP_ADDR = 3'b001,
      DP_TURN = 3'b010,
      DP_HI = 3'b011,
      DP_LO = 3'b100,
      DP_DONE = 3'b101
   } fes_dphase_e;

   typedef struct packed {
      fes_dphase_e phase;
      logic [7:0] cmd;
      logic [15:0] rsp;
      logic [7:0] dq_o;
      logic oe_n;
      logic rds;
      logic stall;
      logic busy;
      logic abort;
      logic wbuf;
      logic ers;
      logic [7:0] flash_status_word;
      logic single_fix_seen;
      logic double_bit_seen;
      logic [UNITS-1:0][2:0] unit_bits;
      logic [15:0] trap_lo;
      logic [15:0] trap_hi;
      logic trapped;
      logic int_pend;
      logic int_n;
      logic arr_last;
      logic op_last;
   } fes_dev_s;

   fes_dev_s state_ff;
   fes_dev_s nxt_state;

   // ==========================================================
   // Input synchronisers into the link clock domain
   logic [36:0] raw_in;
   logic [36:0] sync_in;
   logic rst_n_q;
   logic arr_tgl_q;
   logic [24:3] addr_q;
   logic fix_data_q;
   logic fix_syn_q;
   logic double_q;
   logic unit_off_q;
   logic multi_q;
   logic op_tgl_q;
   logic op_fail_q;
   logic trap_both_q;
   logic stall_off_q;
   logic dbl_en_q;
   logic int_en_q;
   logic [1:0] density_q;

   assign raw_in = {reset_n, arr_toggle, arr_addr, arr_fix_data,
      arr_fix_syn, arr_double, arr_unit_off, arr_multi_prog, op_toggle,
      op_fail, cfg_trap_both, cfg_stall_off, cfg_dbl_en, cfg_int_en,
      cfg_density};

   fes_sync #(.W(37)) u_sync (
      .clk(lnk.link_clk),
      .d(raw_in),
      .q(sync_in)
   );

   assign {rst_n_q, arr_tgl_q, addr_q, fix_data_q, fix_syn_q, double_q,
      unit_off_q, multi_q, op_tgl_q, op_fail_q, trap_both_q, stall_off_q,
      dbl_en_q, int_en_q, density_q} = sync_in;

   // ==========================================================
   // Decode helpers
   function automatic logic takes_addr(input logic [7:0] c);
      takes_addr = (c == CMD_ECC_RD) || (c == CMD_ARR_RD);
   endfunction

   function automatic logic [15:0] hi_mask(input logic [1:0] den);
      if (den == DEN_128)
         hi_mask = HI_MASK_128;
      else if (den == DEN_256)
         hi_mask = HI_MASK_256;
      else
         hi_mask = HI_MASK_512;
   endfunction

   // ==========================================================
   // Next state
   always_comb
   begin
      logic [7:0] ex_cmd;
      logic [7:0] ex_arg;
      logic do_ex;
      logic [15:0] rsp;
      logic [7:0] stat;
      logic fix;
      logic hit;
      ex_cmd = state_ff.cmd;
      ex_arg = 8'h00;
      do_ex = 1'b0;
      rsp = JUNK_WORD;
      stat = FSW_RST;
      fix = fix_data_q | fix_syn_q;
      hit = 1'b0;
      nxt_state = state_ff;
      nxt_state.arr_last = arr_tgl_q;
      nxt_state.op_last = op_tgl_q;

      // Frame sequencing; deselect ends any stall
      if (lnk.cs_n)
      begin
         nxt_state.phase = DP_CMD;
         nxt_state.oe_n = 1'b1;
         nxt_state.rds = 1'b0;
         nxt_state.stall = 1'b0;
      end
      else
      begin
         case (state_ff.phase)
            DP_CMD:
            begin
               nxt_state.cmd = lnk.dq;
               ex_cmd = lnk.dq;
               if (takes_addr(lnk.dq))
                  nxt_state.phase = DP_ADDR;
               else
                  do_ex = 1'b1;
            end
            DP_ADDR:
            begin
               ex_arg = lnk.dq;
               do_ex = 1'b1;
            end
            DP_TURN:
            begin
               nxt_state.dq_o = state_ff.rsp[15:8];
               nxt_state.oe_n = 1'b0;
               nxt_state.rds = 1'b1;
               nxt_state.phase = DP_HI;
            end
            DP_HI:
            begin
               nxt_state.dq_o = state_ff.rsp[7:0];
               nxt_state.rds = 1'b0;
               nxt_state.phase = DP_LO;
            end
            DP_LO:
            begin
               nxt_state.oe_n = 1'b1;
               nxt_state.phase = DP_DONE;
            end
            default:
            begin
               nxt_state.phase = DP_DONE;
            end
         endcase
      end

      // Abort status word or normal status word
      if (state_ff.abort)
         stat = {1'b1, state_ff.flash_status_word[FSW_ERS], 6'b011000};
      else
         stat = {!state_ff.busy, state_ff.flash_status_word[6:0]};

      // Command execution
      if (do_ex)
      begin
         nxt_state.phase = DP_DONE;
         if (!state_ff.abort || ex_cmd == CMD_STAT_RD ||
            ex_cmd == CMD_ABORT_RST || ex_cmd == CMD_STAT_CLR)
         begin
            case (ex_cmd)
               CMD_STAT_RD:
               begin
                  rsp = {8'h00, stat};
                  nxt_state.phase = DP_TURN;
               end
               CMD_STAT_CLR, CMD_ABORT_RST:
               begin
                  if (state_ff.abort)
                  begin
                     nxt_state.busy = 1'b0;
                     nxt_state.abort = 1'b0;
                     nxt_state.wbuf = 1'b0;
                  end
                  nxt_state.flash_status_word = FSW_RST;
                  if (ex_cmd == CMD_STAT_CLR)
                     nxt_state.int_pend = 1'b0;
               end
               CMD_EXIT:
               begin
                  nxt_state.single_fix_seen = 1'b0;
                  nxt_state.double_bit_seen = 1'b0;
                  nxt_state.unit_bits = '0;
                  nxt_state.trapped = 1'b0;
                  nxt_state.trap_lo = ECC_RST;
                  nxt_state.trap_hi = ECC_RST;
               end
               CMD_ECC_RD:
               begin
                  rsp = {ECC_RSVD, state_ff.double_bit_seen,
                     state_ff.single_fix_seen,
                     state_ff.unit_bits[ex_arg[UNIT_AW-1:0]]};
                  nxt_state.phase = DP_TURN;
               end
               CMD_TRAP_LO:
               begin
                  rsp = state_ff.trap_lo;
                  nxt_state.phase = DP_TURN;
               end
               CMD_TRAP_HI:
               begin
                  rsp = state_ff.trap_hi;
                  nxt_state.phase = DP_TURN;
               end
               CMD_ARR_RD:
               begin
                  nxt_state.phase = DP_TURN;
               end
               CMD_PROG, CMD_ERASE, CMD_WBUF:
               begin
                  if (!state_ff.busy)
                  begin
                     nxt_state.busy = 1'b1;
                     nxt_state.ers = (ex_cmd == CMD_ERASE);
                     nxt_state.wbuf = (ex_cmd == CMD_WBUF);
                     if (ex_cmd == CMD_ERASE)
                        nxt_state.flash_status_word[FSW_ERS] = 1'b0;
                     else
                        nxt_state.flash_status_word[FSW_PGM] = 1'b0;
                  end
               end
               default:
               begin
                  nxt_state.phase = DP_DONE;
               end
            endcase
         end
         if (state_ff.busy && ex_cmd != CMD_STAT_RD)
            rsp = JUNK_WORD;
         nxt_state.rsp = rsp;
      end

      // Embedded operation completion
      if (op_tgl_q != state_ff.op_last && state_ff.busy && !state_ff.abort)
      begin
         if (op_fail_q && state_ff.wbuf)
            nxt_state.abort = 1'b1;
         else
         begin
            nxt_state.busy = 1'b0;
            nxt_state.wbuf = 1'b0;
            if (op_fail_q && state_ff.ers)
               nxt_state.flash_status_word[FSW_ESF] = 1'b1;
            else if (op_fail_q)
               nxt_state.flash_status_word[FSW_PGM] = 1'b1;
         end
      end

      // Half-page read results; applied after clears so a set wins
      if (arr_tgl_q != state_ff.arr_last && !(multi_q && !dbl_en_q))
      begin
         nxt_state.unit_bits[addr_q[UNIT_LSB +: UNIT_AW]] =
            {fix_syn_q, fix_data_q, unit_off_q};
         if (fix)
            nxt_state.single_fix_seen = 1'b1;
         if (double_q)
            nxt_state.double_bit_seen = 1'b1;
         if (fix || double_q)
            nxt_state.int_pend = 1'b1;
         hit = double_q ||
            (fix && trap_both_q && density_q != DEN_512);
         if (hit && !nxt_state.trapped)
         begin
            nxt_state.trapped = 1'b1;
            nxt_state.trap_lo = {addr_q[15:3], 3'b000};
            nxt_state.trap_hi = {7'h00, addr_q[24:16]} &
               hi_mask(density_q);
         end
         if (double_q && !stall_off_q && !lnk.cs_n)
            nxt_state.stall = 1'b1;
      end

      // Outputs derived from state
      if (nxt_state.stall)
         nxt_state.rds = 1'b0;
      nxt_state.int_n = !(int_en_q && nxt_state.int_pend);

      if (!rst_n_q)
      begin
         nxt_state = '0;
         nxt_state.phase = DP_CMD;
         nxt_state.oe_n = 1'b1;
         nxt_state.int_n = 1'b1;
         nxt_state.arr_last = arr_tgl_q;
         nxt_state.op_last = op_tgl_q;
      end
   end

   always_ff @(posedge lnk.link_clk)
   begin
      state_ff <= nxt_state;
   end

   // ==========================================================
   // Link outputs
   assign lnk.dq_d = state_ff.dq_o;
   assign lnk.d_oe_n = state_ff.oe_n;
   assign lnk.read_data_strobe = state_ff.rds;
   assign lnk.int_n = state_ff.int_n;
endmodule
`default_nettype wire

// File: hdl/fes_host.sv
// Host controller end: frames commands and reads status words
`timescale 1ns/1ps
`default_nettype none
module fes_host (
   input wire logic ref_clk,
   input wire logic reset_n,
   fes_link_if.host lnk,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_addr,
   input wire logic cmd_addr_en,
   input wire logic cmd_read,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic bus_error
);
   import fes_pkg::*;

   // ==========================================================
   // Types and state
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_CMD = 3'b001,
      H_ADDR = 3'b010,
      H_REL = 3'b011,
      H_WAIT = 3'b100,
      H_END = 3'b101
   } fes_hst_e;

   typedef struct packed {
      fes_hst_e st;
      logic [1:0] div;
      logic lclk;
      logic cs_n;
      logic [7:0] dq_h;
      logic oe_n;
      logic [7:0] code;
      logic [7:0] arg;
      logic arg_en;
      logic rd;
      logic ready;
      logic rds_last;
      logic cap;
      logic nrx;
      logic [15:0] data;
      logic [5:0] quiet;
      logic rsp_valid;
      logic bus_err;
   } fes_hst_s;

   fes_hst_s state_ff;
   fes_hst_s nxt_state;
   logic [8:0] rx_q;

   // Strobe and data from the far clock domain
   fes_sync #(.W(9)) u_sync (
      .clk(ref_clk),
      .d({lnk.read_data_strobe, lnk.dq}),
      .q(rx_q)
   );

   // ==========================================================
   // Next state
   always_comb
   begin
      logic tick;
      tick = (state_ff.div == DIV_LAST);
      nxt_state = state_ff;
      nxt_state.rsp_valid = 1'b0;
      nxt_state.bus_err = 1'b0;
      nxt_state.cap = 1'b0;
      nxt_state.div = tick ? 2'b00 : state_ff.div + 2'b01;
      nxt_state.lclk = (nxt_state.div >= DIV_HALF);
      case (state_ff.st)
         H_IDLE:
         begin
            nxt_state.ready = 1'b1;
            if (cmd_valid && state_ff.ready)
            begin
               nxt_state.ready = 1'b0;
               nxt_state.code = cmd_code;
               nxt_state.arg = cmd_addr;
               nxt_state.arg_en = cmd_addr_en;
               nxt_state.rd = cmd_read;
               nxt_state.st = H_CMD;
            end
         end
         H_CMD:
         begin
            if (tick)
            begin
               nxt_state.cs_n = 1'b0;
               nxt_state.oe_n = 1'b0;
               nxt_state.dq_h = state_ff.code;
               if (state_ff.arg_en)
                  nxt_state.st = H_ADDR;
               else
                  nxt_state.st = state_ff.rd ? H_REL : H_END;
            end
         end
         H_ADDR:
         begin
            if (tick)
            begin
               nxt_state.dq_h = state_ff.arg;
               nxt_state.st = state_ff.rd ? H_REL : H_END;
            end
         end
         H_REL:
         begin
            if (tick)
            begin
               nxt_state.oe_n = 1'b1;
               nxt_state.quiet = 6'h00;
               nxt_state.nrx = 1'b0;
               nxt_state.rds_last = rx_q[8];
               nxt_state.st = H_WAIT;
            end
         end
         H_WAIT:
         begin
            if (rx_q[8] != state_ff.rds_last)
            begin
               nxt_state.rds_last = rx_q[8];
               nxt_state.cap = 1'b1;
               nxt_state.quiet = 6'h00;
            end
            else if (tick)
               nxt_state.quiet = state_ff.quiet + 6'h01;
            if (state_ff.cap)
            begin
               // Raw word; reserved and fix bits left to software
               nxt_state.data = {state_ff.data[7:0], rx_q[7:0]};
               nxt_state.nrx = 1'b1;
               if (state_ff.nrx)
               begin
                  nxt_state.rsp_valid = 1'b1;
                  nxt_state.st = H_END;
               end
            end
            else if (state_ff.quiet > STALL_LIMIT)
            begin
               nxt_state.bus_err = 1'b1;
               nxt_state.st = H_END;
            end
         end
         default:
         begin
            if (tick)
            begin
               nxt_state.cs_n = 1'b1;
               nxt_state.oe_n = 1'b1;
               nxt_state.st = H_IDLE;
            end
         end
      endcase
      if (!reset_n)
      begin
         nxt_state = '0;
         nxt_state.cs_n = 1'b1;
         nxt_state.oe_n = 1'b1;
         // Link clock keeps running so the flash end sees reset too
         if (state_ff.cs_n)
         begin
            nxt_state.div = state_ff.div + 2'b01;
            nxt_state.lclk = (nxt_state.div >= DIV_HALF);
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      state_ff <= nxt_state;
   end

   // ==========================================================
   // Outputs
   assign lnk.link_clk = state_ff.lclk;
   assign lnk.cs_n = state_ff.cs_n;
   assign lnk.dq_h = state_ff.dq_h;
   assign lnk.h_oe_n = state_ff.oe_n;
   assign cmd_ready = state_ff.ready;
   assign rsp_valid = state_ff.rsp_valid;
   assign rsp_data = state_ff.data;
   assign bus_error = state_ff.bus_err;
endmodule
`default_nettype wire

// File: tb/fes_link_sva.sv
// Link protocol checker for the flash error status link
`timescale 1ns/1ps
`default_nettype none
module fes_link_sva
   import fes_pkg::*;
(
   input wire logic link_clk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic [7:0] dq_h,
   input wire logic h_oe_n,
   input wire logic [7:0] dq_d,
   input wire logic d_oe_n,
   input wire logic [7:0] dq,
   input wire logic read_data_strobe,
   input wire logic int_n
);
   // ==========================================================
   // Clocking and answer steps
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!reset_n);

   sequence hi_byte;
      $fell(d_oe_n) && read_data_strobe;
   endsequence

   sequence lo_byte;
      !d_oe_n && !read_data_strobe;
   endsequence

   sequence clr_cmd;
      $fell(cs_n) && dq == CMD_STAT_CLR;
   endsequence

   // ==========================================================
   // Wire and framing checks
   no_contention_a: assert property (!(!h_oe_n && !d_oe_n))
      else $error("both ends drive the data wire");
   idle_release_a: assert property (cs_n [*2] |-> d_oe_n)
      else $error("device drives while deselected");
   strobe_park_a: assert property (cs_n [*2] |-> !read_data_strobe)
      else $error("strobe not parked low between frames");
   idle_wire_a: assert property (cs_n [*2] |-> dq == 8'hff)
      else $error("idle data wire not pulled high");
   frame_start_a: assert property ($fell(cs_n) |-> !h_oe_n)
      else $error("frame opened without command byte");
   byte_order_a: assert property (hi_byte |=> lo_byte ##1 d_oe_n)
      else $error("answer bytes out of order");
   int_clear_a: assert property (clr_cmd |-> ##[1:8] int_n)
      else $error("interrupt not released by status clear");
   drive_select_a: assert property (!d_oe_n |-> !$past(cs_n))
      else $error("device drives outside a frame");
   strobe_drive_a: assert property (read_data_strobe |-> !d_oe_n)
      else $error("strobe high without data driven");
endmodule
`default_nettype wire

// File: tb/tb_flash_error_status_ecc_trap.sv
// Self-checking bench for the flash error status link ends
`timescale 1ns/1ps
`default_nettype none
module tb_flash_error_status_ecc_trap;
   import fes_pkg::*;
   logic ref_clk = 1'h0;
   logic reset_n = 1'h0;
   logic cmd_valid = 1'h0;
   logic [7:0] cmd_code = 8'h00;
   logic [7:0] cmd_addr = 8'h00;
   logic cmd_addr_en = 1'h0;
   logic cmd_read = 1'h0;
   logic cmd_ready;
   logic rsp_valid;
   logic [15:0] rsp_data;
   logic bus_error;
   logic [24:3] arr_addr = 22'h00_0000;
   logic [2:0] arr_fix = 3'h0;
   logic arr_toggle = 1'h0;
   logic arr_double = 1'h0;
   logic arr_multi_prog = 1'h0;
   logic op_toggle = 1'h0;
   logic op_fail = 1'h0;
   logic cfg_trap_both = 1'h1;
   logic cfg_dbl_en = 1'h1;
   logic cfg_stall_off = 1'h1;
   logic cfg_int_en = 1'h1;
   logic [1:0] cfg_density = DEN_256;
   logic [15:0] d;
   logic e;
   logic [7:0] clr [2] = '{CMD_ABORT_RST, CMD_STAT_CLR};
   logic [24:0] adr_a = 25'h1a5_c3b8;
   logic [24:0] adr_b = 25'h0f0_0120;
   logic [24:0] adr_c = 25'h033_0070;
   logic [24:0] adr_d = 25'h1f3_5a40;
   int num_errors = 0;
   int tests_run = 0;

   // ==========================================================
   // Clock, link and the two ends
   always #2 ref_clk = ~ref_clk;

   fes_link_if i_fes_link_if ();

   fes_host i_fes_host (.ref_clk(ref_clk), .reset_n(reset_n),
      .lnk(i_fes_link_if), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_addr(cmd_addr), .cmd_addr_en(cmd_addr_en),
      .cmd_read(cmd_read), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus_error(bus_error));

   fes_dev i_fes_dev (.lnk(i_fes_link_if), .reset_n(reset_n),
      .arr_toggle(arr_toggle), .arr_addr(arr_addr),
      .arr_fix_data(arr_fix[1]), .arr_fix_syn(arr_fix[2]),
      .arr_double(arr_double), .arr_unit_off(arr_fix[0]),
      .arr_multi_prog(arr_multi_prog), .op_toggle(op_toggle),
      .op_fail(op_fail), .cfg_trap_both(cfg_trap_both),
      .cfg_stall_off(cfg_stall_off), .cfg_dbl_en(cfg_dbl_en),
      .cfg_int_en(cfg_int_en), .cfg_density(cfg_density));

   fes_link_sva i_fes_link_sva (.link_clk(i_fes_link_if.link_clk),
      .reset_n(reset_n), .cs_n(i_fes_link_if.cs_n),
      .dq_h(i_fes_link_if.dq_h), .h_oe_n(i_fes_link_if.h_oe_n),
      .dq_d(i_fes_link_if.dq_d), .d_oe_n(i_fes_link_if.d_oe_n),
      .dq(i_fes_link_if.dq), .int_n(i_fes_link_if.int_n),
      .read_data_strobe(i_fes_link_if.read_data_strobe));

   // ==========================================================
   // Compare, transfer and event tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      while (cmd_ready !== 1'h1 && n < 500)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 500)
         num_errors++;
   endtask

   task automatic xfer(input logic [7:0] c, input logic [7:0] a,
      input logic rd);
      int n;
      n = 0;
      wait_rdy();
      cmd_code = c;
      cmd_addr = a;
      cmd_read = rd;
      cmd_addr_en = (c == CMD_ECC_RD) || (c == CMD_ARR_RD);
      cmd_valid = 1'h1;
      @(negedge ref_clk);
      cmd_valid = 1'h0;
      while (rd && rsp_valid !== 1'h1 && bus_error !== 1'h1 && n < 500)
      begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 500)
         num_errors++;
      d = rsp_data;
      e = bus_error;
      @(negedge ref_clk);
      // Frame fully sent before the caller looks at the far end
      wait_rdy();
   endtask

   task automatic rdc(input logic [7:0] c, input logic [7:0] a,
      input logic [15:0] m, input logic [15:0] e);
      xfer(c, a, 1'h1);
      check(d & m, e);
   endtask

   task automatic ev(input logic [24:0] a, input logic [2:0] f,
      input logic dbl, input logic mp);
      arr_addr = a[24:3];
      arr_fix = f;
      arr_double = dbl;
      arr_multi_prog = mp;
      repeat (16) @(negedge ref_clk);
      arr_toggle = ~arr_toggle;
      repeat (16) @(negedge ref_clk);
   endtask

   task automatic op_end(input logic f);
      op_fail = f;
      repeat (16) @(negedge ref_clk);
      op_toggle = ~op_toggle;
      repeat (16) @(negedge ref_clk);
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial
   begin
      repeat (16) @(negedge ref_clk);
      reset_n = 1'h1;
      repeat (40) @(negedge ref_clk);
      rdc(CMD_STAT_RD, 8'h00, 16'hffbe, 16'h0080);
      rdc(CMD_ECC_RD, 8'h00, 16'h001f, 16'h0000);
      tend("reset");
      xfer(CMD_PROG, 8'h00, 1'h0);
      rdc(CMD_STAT_RD, 8'h00, 16'hffbe, 16'h0000);
      rdc(CMD_ECC_RD, 8'h00, 16'hffff, 16'hffff);
      op_end(1'h1);
      rdc(CMD_STAT_RD, 8'h00, 16'hffbe, 16'h0090);
      xfer(CMD_PROG, 8'h00, 1'h0);
      rdc(CMD_STAT_RD, 8'h00, 16'hffbe, 16'h0000);
      op_end(1'h0);
      tend("program");
      foreach (clr[i])
      begin
         xfer(CMD_WBUF, 8'h00, 1'h0);
         op_end(1'h1);
         rdc(CMD_STAT_RD, 8'h00, 16'hffbe, 16'h0098);
         xfer(CMD_ERASE, 8'h00, 1'h0);
         rdc(CMD_STAT_RD, 8'h00, 16'hffbe, 16'h0098);
         xfer(clr[i], 8'h00, 1'h0);
         rdc(CMD_STAT_RD, 8'h00, 16'hffbe, 16'h0080);
      end
      tend("abort");
      ev(adr_a, 3'h6, 1'h0, 1'h0);
      rdc(CMD_ECC_RD, {4'h0, adr_a[7:4]}, 16'h001f, 16'h000e);
      rdc(CMD_ECC_RD, 8'h05, 16'h001f, 16'h0008);
      rdc(CMD_TRAP_LO, 8'h00, 16'hffff, adr_a[15:0] & 16'hfff8);
      rdc(CMD_TRAP_HI, 8'h00, 16'hffff,
         {7'h00, adr_a[24:16]} & HI_MASK_256);
      check({15'h0000, i_fes_link_if.int_n}, 16'h0000);
      ev(adr_b, 3'h0, 1'h1, 1'h0);
      rdc(CMD_ECC_RD, {4'h0, adr_b[7:4]}, 16'h0010, 16'h0010);
      rdc(CMD_TRAP_LO, 8'h00, 16'hffff, adr_a[15:0] & 16'hfff8);
      xfer(CMD_STAT_CLR, 8'h00, 1'h0);
      check({15'h0000, i_fes_link_if.int_n}, 16'h0001);
      xfer(CMD_EXIT, 8'h00, 1'h0);
      rdc(CMD_ECC_RD, {4'h0, adr_a[7:4]}, 16'h001f, 16'h0000);
      rdc(CMD_TRAP_LO, 8'h00, 16'hffff, 16'h0000);
      tend("ecc");
      cfg_density = DEN_512;
      cfg_dbl_en = 1'h0;
      ev(adr_c, 3'h0, 1'h1, 1'h1);
      rdc(CMD_TRAP_LO, 8'h00, 16'hffff, 16'h0000);
      cfg_dbl_en = 1'h1;
      ev(adr_c, 3'h2, 1'h0, 1'h0);
      rdc(CMD_TRAP_LO, 8'h00, 16'hffff, 16'h0000);
      ev(adr_d, 3'h0, 1'h1, 1'h0);
      rdc(CMD_TRAP_LO, 8'h00, 16'hffff, adr_d[15:0] & 16'hfff8);
      rdc(CMD_TRAP_HI, 8'h00, 16'hffff,
         {7'h00, adr_d[24:16]} & HI_MASK_512);
      tend("trap");
      // Two-bit result inside a read frame stalls the strobe
      cfg_stall_off = 1'h0;
      arr_double = 1'h1;
      repeat (16) @(negedge ref_clk);
      fork
         xfer(CMD_ARR_RD, 8'h10, 1'h1);
         begin
            @(negedge cmd_ready);
            @(negedge ref_clk);
            arr_toggle = ~arr_toggle;
         end
      join
      check({15'h0000, e}, 16'h0001);
      cfg_int_en = 1'h0;
      repeat (16) @(negedge ref_clk);
      check({15'h0000, i_fes_link_if.int_n}, 16'h0001);
      tend("stall");
      finish_test();
   end

   // Watchdog against a hung handshake
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      num_errors++;
      finish_test();
   end
endmodule
`default_nettype wire
